// file: rtl/lbms_pkg.sv
// Shared constants, types and helpers for the lamp ballast mode sequencer
package lbms_pkg;

    typedef logic [15:0] lbms_word_t;

    // Register offsets on the plain register port
    localparam logic [4:0] ADDR_PH_ON = 5'h00;
    localparam logic [4:0] ADDR_RUN_ON = 5'h04;
    localparam logic [4:0] ADDR_DEAD = 5'h08;
    localparam logic [4:0] ADDR_ARM = 5'h0c;
    localparam logic [4:0] ADDR_STRIKE = 5'h10;
    localparam logic [4:0] ADDR_STEP = 5'h14;
    localparam logic [4:0] ADDR_STATUS = 5'h18;
    localparam logic [4:0] ADDR_LEVEL = 5'h1c;

    // Values after reset, in core_clk cycles or timer counts
    localparam lbms_word_t RST_PH_ON = 16'h0014;
    localparam lbms_word_t RST_RUN_ON = 16'h0020;
    localparam lbms_word_t RST_DEAD = 16'h0005;
    localparam lbms_word_t RST_ARM = 16'h0200;
    localparam lbms_word_t RST_STRIKE = 16'h0380;
    localparam lbms_word_t RST_STEP = 16'h0010;

    // Sweep is cut into sixteen steps; step index 16 means run period
    localparam logic [4:0] SWEEP_STEPS = 5'h10;
    localparam lbms_word_t SAG_PULL = 16'h0004;
    localparam lbms_word_t LEVEL_MAX = 16'hffff;

    // Status word field positions
    localparam int STAT_MODE_LSB = 0;
    localparam int STAT_ARMED_BIT = 3;
    localparam int STAT_SD_BIT = 4;
    localparam int STAT_TOP_BIT = 5;
    localparam int STAT_BOT_BIT = 6;

    // Operating modes, Gray coded along lockout, preheat, strike, run
    typedef enum logic [2:0] {
        LBMS_LOCKOUT = 3'h0,
        LBMS_PREHEAT = 3'h1,
        LBMS_STRIKE = 3'h3,
        LBMS_RUN = 3'h2,
        LBMS_FAULT = 3'h6
    } lbms_mode_t;

    // Oscillator ramp phases
    typedef enum logic [1:0] {
        LBMS_HOLD = 2'h0,
        LBMS_CHARGE = 2'h1,
        LBMS_DISCHARGE = 2'h3
    } lbms_phase_t;

    // Stepwise interpolation from a toward b, s sixteenths of the way
    function automatic lbms_word_t lbms_lerp(lbms_word_t a, lbms_word_t b, logic [4:0] s);
        logic [20:0] d;
        d = 21'h0;
        if (b >= a)
        begin
            d = {5'h0, b - a} * {16'h0, s};
            return a + d[19:4];
        end
        d = {5'h0, a - b} * {16'h0, s};
        return a - d[19:4];
    endfunction

endpackage

// file: rtl/lbms_core_if.sv
// Links between the mode sequencer, its oscillator and its preheat timer
`timescale 1ns/1ns
interface lbms_core_if;
    import lbms_pkg::*;
    logic hold;
    lbms_word_t on_cycles;
    lbms_word_t dead_cycles;
    logic top;
    logic bottom;
    logic clear;
    logic sag;
    lbms_word_t strike_level;
    lbms_word_t step_len;
    lbms_word_t level;
    logic [4:0] step;

    modport ctl (output hold, on_cycles, dead_cycles, clear, sag, strike_level, step_len,
                 input top, bottom, level, step);
    modport osc (input hold, on_cycles, dead_cycles, output top, bottom);
    modport tmr (input clear, sag, strike_level, step_len, output level, step);
endinterface

// file: rtl/lbms_oscillator.sv
// Half-bridge oscillator: ramp phases and the two gate flops
`timescale 1ns/1ns
module lbms_oscillator (
    input wire logic core_clk,
    input wire logic rst_b,
    lbms_core_if.osc osc
);
    import lbms_pkg::*;

    lbms_phase_t phase_r;
    lbms_word_t cnt_r;
    logic side_r;
    logic top_r;
    logic bot_r;
    logic saw_bot_r;

    // Ramp phase and cycle counter; hold grounds the ramp at once
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            phase_r <= LBMS_HOLD;
            cnt_r <= 16'h0000;
            side_r <= 1'b0;
        end
        else if (osc.hold)
        begin
            phase_r <= LBMS_HOLD;
            cnt_r <= 16'h0000;
            side_r <= 1'b0;         // Next start is on the bottom gate
        end
        else if (phase_r == LBMS_HOLD)
        begin
            phase_r <= LBMS_CHARGE;
            cnt_r <= 16'h0001;
        end
        else if (phase_r == LBMS_CHARGE && cnt_r >= osc.on_cycles)
        begin
            phase_r <= LBMS_DISCHARGE;   // Charging path off
            cnt_r <= 16'h0001;
            side_r <= ~side_r;
        end
        else if (phase_r == LBMS_DISCHARGE && cnt_r >= osc.dead_cycles)
        begin
            phase_r <= LBMS_CHARGE;      // Opposite gate takes its turn
            cnt_r <= 16'h0001;
        end
        else
        begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end

    // Gates: on only while charging, chosen by side
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            top_r <= 1'b0;
            bot_r <= 1'b0;
        end
        else if (osc.hold)
        begin
            top_r <= 1'b0;
            bot_r <= 1'b0;
        end
        else if (phase_r == LBMS_CHARGE && cnt_r >= osc.on_cycles)
        begin
            top_r <= 1'b0;           // Dead-time, both off
            bot_r <= 1'b0;
        end
        else if (phase_r != LBMS_CHARGE && (phase_r == LBMS_HOLD || cnt_r >= osc.dead_cycles))
        begin
            top_r <= side_r;
            bot_r <= ~side_r;
        end
    end

    assign osc.top = top_r;
    assign osc.bottom = bot_r;

    // Helper for checking which gate fires first after a hold
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            saw_bot_r <= 1'b0;
        else if (osc.hold)
            saw_bot_r <= 1'b0;
        else if (bot_r)
            saw_bot_r <= 1'b1;
    end

    default clocking osc_cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    first_bottom_a: assert property ($rose(top_r) |-> saw_bot_r)
        else $error("top gate fired before any bottom pulse");
    no_overlap_a: assert property (!(top_r && bot_r) && !($fell(top_r) && bot_r))
        else $error("gates overlap or no dead-time after top");
endmodule

// file: rtl/lbms_preheat_timer.sv
// Preheat timer level and ignition sweep step counter
`timescale 1ns/1ns
module lbms_preheat_timer (
    input wire logic core_clk,
    input wire logic rst_b,
    lbms_core_if.tmr tmr
);
    import lbms_pkg::*;

    lbms_word_t level_r;
    lbms_word_t sub_r;
    logic [4:0] step_r;

    // Level rises one count a cycle; sag pulls it down
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            level_r <= 16'h0000;
        else if (tmr.clear)
            level_r <= 16'h0000;
        else if (tmr.sag)
            level_r <= (level_r > SAG_PULL) ? level_r - SAG_PULL : 16'h0000;
        else if (level_r != LEVEL_MAX)
            level_r <= level_r + 16'h0001;
    end

    // Sweep steps advance above the strike level; a sag restarts them
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sub_r <= 16'h0000;
            step_r <= 5'h00;
        end
        else if (tmr.clear || tmr.sag)
        begin
            sub_r <= 16'h0000;                      // Sweep reset, re-run later
            step_r <= 5'h00;
        end
        else if (level_r > tmr.strike_level && step_r != SWEEP_STEPS)
        begin
            if (sub_r + 16'h0001 >= tmr.step_len)
            begin
                sub_r <= 16'h0000;
                step_r <= step_r + 5'h01;
            end
            else
                sub_r <= sub_r + 16'h0001;
        end
    end

    assign tmr.level = level_r;
    assign tmr.step = step_r;

    default clocking tmr_cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    sag_pull_a: assert property (tmr.sag && !tmr.clear && level_r != 16'h0000
        |=> level_r < $past(level_r) && step_r == 5'h00)
        else $error("sag did not pull the timer down");
    clear_level_a: assert property (tmr.clear |=> level_r == 16'h0000 && step_r == 5'h00)
        else $error("timer not cleared");
endmodule

// file: rtl/lbms_top.sv
// Lamp ballast mode sequencer: modes, protection and register port
// Operation
// - Lockout keeps both gates low, ramp grounded, preheat timer cleared.
// - Leave lockout only with supply above turn-on and shutdown below low threshold.
// - First gate pulse after lockout is on the bottom gate.
// - Preheat alternates gates at preheat period, equal halves, dead-time between.
// - Gate on-time is the ramp charging phase; charging then stops.
// - Ramp discharge is dead-time with both gates off; then the other gate.
// - Over-current ignored early in preheat; it and sag act above the arm level.
// - Stay at preheat period until timer passes strike level, then enter strike.
// - In strike, period sweeps stepwise from preheat to run as timer rises.
// - Run mode uses the run period alone.
// - Armed over-current after preheat start enters fault with gates latched low.
// - Fault clears the preheat timer and grounds the ramp.
// - Fault exits only by supply drop or shutdown request, both into lockout.
// - After fault clears, restart in preheat when supply and shutdown allow.
// - Bus sag pulls the preheat timer down, raising frequency, resetting the sweep.
// - After a sag the strike sweep re-runs by itself, no lockout needed.
//
// The register addresses and the plain strobed port were decided locally.
`timescale 1ns/1ns
module lbms_top (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [4:0] reg_addr,
    input wire lbms_pkg::lbms_word_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic supply_above_on,
    input wire logic supply_below_off,
    input wire logic shutdown_above_hi,
    input wire logic shutdown_below_lo,
    input wire logic over_current,
    input wire logic bus_sag,
    output logic top_gate_drive,
    output logic bottom_gate_drive,
    output logic [2:0] mode_state
);
    import lbms_pkg::*;

    lbms_core_if core ();

    lbms_mode_t state_r;
    lbms_mode_t state_nxt;
    lbms_word_t ph_on_r;
    lbms_word_t run_on_r;
    lbms_word_t dead_r;
    lbms_word_t arm_r;
    lbms_word_t strike_r;
    lbms_word_t step_len_r;
    lbms_word_t rdata_r;
    logic sd_active_r;
    logic armed;
    logic lockout_req;
    logic start_ok;

    lbms_oscillator u_osc (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .osc(core.osc)
    );

    lbms_preheat_timer u_tmr (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .tmr(core.tmr)
    );

    // Shutdown request with hysteresis: set high, release only low
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            sd_active_r <= 1'b0;
        else if (shutdown_above_hi)
            sd_active_r <= 1'b1;
        else if (shutdown_below_lo)
            sd_active_r <= 1'b0;
    end

    // Protection gating and lockout conditions
    assign armed = core.level > arm_r;
    assign lockout_req = supply_below_off || sd_active_r || shutdown_above_hi;
    assign start_ok = supply_above_on && shutdown_below_lo && !lockout_req;

    // Next mode; lockout requests override every mode
    always_comb
    begin
        state_nxt = state_r;
        if (lockout_req)
            state_nxt = LBMS_LOCKOUT;
        else
        begin
            case (state_r)
                LBMS_LOCKOUT:
                    if (start_ok)
                        state_nxt = LBMS_PREHEAT;
                LBMS_PREHEAT:
                    if (armed && over_current)
                        state_nxt = LBMS_FAULT;
                    else if (core.level > strike_r)
                        state_nxt = LBMS_STRIKE;
                LBMS_STRIKE:
                    if (armed && over_current)
                        state_nxt = LBMS_FAULT;
                    else if (core.step == SWEEP_STEPS)
                        state_nxt = LBMS_RUN;
                LBMS_RUN:
                    if (armed && over_current)
                        state_nxt = LBMS_FAULT;
                    else if (core.step != SWEEP_STEPS)
                        state_nxt = LBMS_STRIKE;       // Sag reset the sweep
                LBMS_FAULT:
                    state_nxt = LBMS_FAULT;            // Latched until lockout
                default:
                    state_nxt = LBMS_LOCKOUT;
            endcase
        end
    end

    // Mode register
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            state_r <= LBMS_LOCKOUT;
        else
            state_r <= state_nxt;
    end

    // Hold and clear follow the next mode, so gates drop on the same edge
    assign core.hold = (state_nxt == LBMS_LOCKOUT) || (state_nxt == LBMS_FAULT);
    assign core.clear = core.hold;
    assign core.sag = bus_sag && armed;
    assign core.strike_level = strike_r;
    assign core.step_len = step_len_r;
    assign core.dead_cycles = dead_r;

    // On-time per mode; strike interpolates between the two periods
    always_comb
    begin
        case (state_r)
            LBMS_STRIKE: core.on_cycles = lbms_lerp(ph_on_r, run_on_r, core.step);
            LBMS_RUN: core.on_cycles = run_on_r;       // Preheat path fully out
            default: core.on_cycles = ph_on_r;
        endcase
    end

    // Register writes; periods and levels are cycle counts
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ph_on_r <= RST_PH_ON;
            run_on_r <= RST_RUN_ON;
            dead_r <= RST_DEAD;
            arm_r <= RST_ARM;
            strike_r <= RST_STRIKE;
            step_len_r <= RST_STEP;
        end
        else if (reg_wr)
        begin
            if (reg_addr == ADDR_PH_ON)
                ph_on_r <= reg_wdata;
            else if (reg_addr == ADDR_RUN_ON)
                run_on_r <= reg_wdata;
            else if (reg_addr == ADDR_DEAD)
                dead_r <= reg_wdata;
            else if (reg_addr == ADDR_ARM)
                arm_r <= reg_wdata;
            else if (reg_addr == ADDR_STRIKE)
                strike_r <= reg_wdata;
            else if (reg_addr == ADDR_STEP)
                step_len_r <= reg_wdata;
        end
    end

    // Read data stands only in the cycle after the read strobe
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            rdata_r <= 16'h0000;
        else if (!reg_rd)
            rdata_r <= 16'h0000;
        else if (reg_addr == ADDR_PH_ON)
            rdata_r <= ph_on_r;
        else if (reg_addr == ADDR_RUN_ON)
            rdata_r <= run_on_r;
        else if (reg_addr == ADDR_DEAD)
            rdata_r <= dead_r;
        else if (reg_addr == ADDR_ARM)
            rdata_r <= arm_r;
        else if (reg_addr == ADDR_STRIKE)
            rdata_r <= strike_r;
        else if (reg_addr == ADDR_STEP)
            rdata_r <= step_len_r;
        else if (reg_addr == ADDR_STATUS)
        begin
            rdata_r <= 16'h0000;
            rdata_r[STAT_MODE_LSB +: 3] <= state_r;
            rdata_r[STAT_ARMED_BIT] <= armed;
            rdata_r[STAT_SD_BIT] <= sd_active_r;
            rdata_r[STAT_TOP_BIT] <= core.top;
            rdata_r[STAT_BOT_BIT] <= core.bottom;
        end
        else if (reg_addr == ADDR_LEVEL)
            rdata_r <= core.level;
        else
            rdata_r <= 16'h0000;   // Unmapped reads answer zero
    end

    assign reg_rdata = rdata_r;
    assign top_gate_drive = core.top;
    assign bottom_gate_drive = core.bottom;
    assign mode_state = state_r;

    default clocking top_cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    // A fault trip: armed over-current in an oscillating mode
    sequence oc_trip_s;
        armed && over_current && !lockout_req
            && (state_r == LBMS_PREHEAT || state_r == LBMS_STRIKE || state_r == LBMS_RUN);
    endsequence

    // Fault latched with gates low while no lockout request comes
    sequence fault_held_s;
        state_r == LBMS_FAULT && !top_gate_drive && !bottom_gate_drive;
    endsequence

    lockout_quiet_a: assert property (state_r == LBMS_LOCKOUT
        |-> !top_gate_drive && !bottom_gate_drive && core.level == 16'h0000)
        else $error("lockout with gate or timer active");
    lockout_stay_a: assert property (state_r == LBMS_LOCKOUT && !start_ok
        |=> state_r == LBMS_LOCKOUT)
        else $error("left lockout without start conditions");
    lockout_exit_a: assert property (state_r == LBMS_LOCKOUT && start_ok
        |=> state_r == LBMS_PREHEAT)
        else $error("restart not into preheat");
    oc_ignored_a: assert property (state_r == LBMS_PREHEAT && !armed && !lockout_req
        |=> state_r != LBMS_FAULT)
        else $error("over-current acted before arm level");
    oc_fault_a: assert property (oc_trip_s |=> fault_held_s)
        else $error("over-current did not latch fault");
    fault_stay_a: assert property (state_r == LBMS_FAULT && !lockout_req
        |=> fault_held_s ##0 core.level == 16'h0000)
        else $error("fault left without lockout request");
    force_lockout_a: assert property (lockout_req |=> state_r == LBMS_LOCKOUT)
        else $error("lockout request ignored");
    strike_entry_a: assert property (state_r == LBMS_PREHEAT && !lockout_req
        && !(armed && over_current) && core.level > strike_r |=> state_r == LBMS_STRIKE)
        else $error("strike not entered at strike level");
    run_period_a: assert property (state_r == LBMS_RUN |-> core.on_cycles == run_on_r)
        else $error("run mode not at run period");
    sd_hyst_a: assert property (sd_active_r && !shutdown_below_lo && !shutdown_above_hi
        |=> sd_active_r)
        else $error("shutdown released above low threshold");
endmodule

// file: tb/lbms_bridge_model.sv
// Half-bridge switches and lamp stage seen from the gate pins
`timescale 1ns/1ns
module lbms_bridge_model (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic top_gate_drive,
    input wire logic bottom_gate_drive,
    input wire logic hard_switch,
    output logic over_current,
    output logic overlap_seen
);
    // Shunt sits under the bottom switch, so current shows only while it conducts
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            over_current <= 1'b0;
        else
            over_current <= hard_switch && bottom_gate_drive;
    end

    // Both switches on would short the bus; remembered for the bench to judge
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
            overlap_seen <= 1'b0;
        else
            overlap_seen <= overlap_seen || (top_gate_drive && bottom_gate_drive);
    end
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the lamp ballast mode sequencer
`timescale 1ns/1ns
module tb_top;
    import lbms_pkg::*;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [4:0] reg_addr = 5'h00;
    lbms_word_t reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic supply_above_on = 1'b0;
    logic supply_below_off = 1'b0;
    logic shutdown_above_hi = 1'b0;
    logic shutdown_below_lo = 1'b1;
    logic bus_sag = 1'b0;
    logic hard_switch = 1'b0;
    logic over_current;
    logic overlap_seen;
    logic top_gate_drive;
    logic bottom_gate_drive;
    logic [2:0] mode_state;
    int errors = 0;
    int total_checks = 0;
    int n;
    lbms_word_t d;
    lbms_word_t lvl;

    // 25 MHz core clock
    always #20 core_clk = ~core_clk;

    // Block under test and the power stage it drives
    lbms_top u_lbms_top (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .supply_above_on(supply_above_on), .supply_below_off(supply_below_off),
        .shutdown_above_hi(shutdown_above_hi), .shutdown_below_lo(shutdown_below_lo),
        .over_current(over_current), .bus_sag(bus_sag), .top_gate_drive(top_gate_drive),
        .bottom_gate_drive(bottom_gate_drive), .mode_state(mode_state));
    lbms_bridge_model u_lbms_bridge_model (.core_clk(core_clk), .rst_b(rst_b),
        .top_gate_drive(top_gate_drive), .bottom_gate_drive(bottom_gate_drive),
        .hard_switch(hard_switch), .over_current(over_current), .overlap_seen(overlap_seen));

    task automatic final_report;
        if (errors == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Sampling one step after the edge keeps clear of the design's own updates
    task automatic tick;
        @(posedge core_clk);
        #1;
    endtask

    task automatic mode_is(input logic [2:0] m);
        check({13'h0, mode_state}, {13'h0, m});
    endtask

    task automatic gates(input logic [1:0] e);
        check({14'h0, top_gate_drive, bottom_gate_drive}, {14'h0, e});
    endtask

    // Always lets one edge pass, so a request made at this edge is seen first
    task automatic wait_mode(input logic [2:0] m, input int lim);
        int i;
        i = 0;
        do
        begin
            tick;
            i++;
        end
        while (mode_state !== m && i < lim);
        mode_is(m);
        if (mode_state !== m)
            final_report;
    endtask

    task automatic wr(input logic [4:0] a, input lbms_word_t v);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, output lbms_word_t v);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask

    task automatic start_check;
        wait_mode(LBMS_PREHEAT, 4);
        gates(2'b01);
        tick;
        gates(2'b01);
    endtask

    // Measures one on-time and the dead-time after it, then the hand-over
    task automatic pulse(input logic upper, input lbms_word_t on_exp);
        n = 0;
        while ((upper ? top_gate_drive : bottom_gate_drive) === 1'b1 && n < 1000)
        begin
            n++;
            tick;
        end
        check(16'(n), on_exp);
        n = 0;
        while ({top_gate_drive, bottom_gate_drive} === 2'b00 && n < 1000)
        begin
            n++;
            tick;
        end
        check(16'(n), RST_DEAD);
        gates(upper ? 2'b01 : 2'b10);
    endtask

    // Skips to the start of the next on-time
    task automatic skip_half;
        n = 0;
        while ((top_gate_drive | bottom_gate_drive) === 1'b1 && n < 1000)
        begin
            n++;
            tick;
        end
        while ((top_gate_drive | bottom_gate_drive) === 1'b0 && n < 2000)
        begin
            n++;
            tick;
        end
    endtask

    task automatic t_lockout;
        lbms_word_t rv [6] = '{RST_PH_ON, RST_RUN_ON, RST_DEAD, RST_ARM, RST_STRIKE, RST_STEP};
        repeat (20)
        begin
            tick;
            gates(2'b00);
        end
        mode_is(LBMS_LOCKOUT);
        for (int i = 0; i < 6; i++)
        begin
            rd(5'(i * 4), d);
            check(d, rv[i]);
        end
        wr(ADDR_LEVEL, 16'hffff);
        rd(ADDR_LEVEL, d);
        check(d, 16'h0000);
        rd(5'h02, d);
        check(d, 16'h0000);
        @(posedge core_clk);
        supply_above_on <= 1'b1;
        shutdown_below_lo <= 1'b0;
        repeat (10) tick;
        mode_is(LBMS_LOCKOUT);
    endtask

    task automatic t_start;
        @(posedge core_clk);
        shutdown_below_lo <= 1'b1;
        start_check;
        // Bottom rises with the mode change; start_check has used one on-cycle
        pulse(1'b0, RST_PH_ON - 16'h0001);
        pulse(1'b1, RST_PH_ON);
        pulse(1'b0, RST_PH_ON);
        pulse(1'b1, RST_PH_ON);
    endtask

    // Over-current early in preheat, before the arm level, changes nothing
    task automatic t_early;
        @(posedge core_clk);
        hard_switch <= 1'b1;
        repeat (40)
        begin
            tick;
            mode_is(LBMS_PREHEAT);
        end
        @(posedge core_clk);
        hard_switch <= 1'b0;
    endtask

    // Short counts make the strike sweep and run entry quick
    task automatic t_strike_run;
        wr(ADDR_ARM, 16'h0080);
        wr(ADDR_STRIKE, 16'h00a0);
        wr(ADDR_STEP, 16'h0002);
        rd(ADDR_STRIKE, d);
        check(d, 16'h00a0);
        wait_mode(LBMS_STRIKE, 300);
        rd(ADDR_LEVEL, d);
        check(16'(d > 16'h00a0), 16'h0001);
        wait_mode(LBMS_RUN, 100);
        rd(ADDR_STATUS, d);
        check(d & 16'h001f, 16'h000a);
        skip_half;
        skip_half;
        pulse(top_gate_drive, RST_RUN_ON);
    endtask

    task automatic t_sag;
        rd(ADDR_LEVEL, lvl);
        @(posedge core_clk);
        bus_sag <= 1'b1;
        repeat (8) @(posedge core_clk);
        bus_sag <= 1'b0;
        #1;
        mode_is(LBMS_STRIKE);
        rd(ADDR_LEVEL, d);
        check(16'(d < lvl), 16'h0001);
        wait_mode(LBMS_RUN, 100);
    endtask

    // A short excursion above the upper threshold stays latched until the lower one
    task automatic t_shutdown;
        @(posedge core_clk);
        shutdown_above_hi <= 1'b1;
        shutdown_below_lo <= 1'b0;
        @(posedge core_clk);
        shutdown_above_hi <= 1'b0;
        wait_mode(LBMS_LOCKOUT, 3);
        repeat (10)
        begin
            tick;
            mode_is(LBMS_LOCKOUT);
            gates(2'b00);
        end
        @(posedge core_clk);
        shutdown_below_lo <= 1'b1;
        start_check;
    endtask

    task automatic t_fault(input logic by_supply);
        @(posedge core_clk);
        hard_switch <= 1'b1;
        wait_mode(LBMS_FAULT, 600);
        gates(2'b00);
        @(posedge core_clk);
        hard_switch <= 1'b0;
        repeat (20) tick;
        mode_is(LBMS_FAULT);
        gates(2'b00);
        rd(ADDR_LEVEL, d);
        check(d, 16'h0000);
        @(posedge core_clk);
        supply_above_on <= !by_supply;
        supply_below_off <= by_supply;
        shutdown_above_hi <= !by_supply;
        shutdown_below_lo <= 1'b0;
        wait_mode(LBMS_LOCKOUT, 3);
        @(posedge core_clk);
        supply_above_on <= 1'b1;
        supply_below_off <= 1'b0;
        shutdown_above_hi <= 1'b0;
        shutdown_below_lo <= 1'b1;
        start_check;
    endtask

    // Main sequence
    initial
    begin
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        t_lockout;
        t_start;
        t_early;
        t_strike_run;
        t_sag;
        t_shutdown;
        t_fault(1'b1);
        t_fault(1'b0);
        check({15'h0, overlap_seen}, 16'h0000);
        final_report;
    end
endmodule
